// ### slc_sysctl.sv
// system control: power states, monitors, soft reset, irq pin
// assumes pins and comparators asynchronous, ext events on MCLK
// Operation
// - power-up reset returns registers to defaults and keeps LEDs off.
// - supply or regulator power-on-reset comparator resets whole device.
// - enable low keeps shutdown, circuits idle, serial port unresponsive.
// - enable high gives standby: oscillator off, regulator low, port open.
// - chip-active bit written 1 in standby moves to active.
// - chip-active bit cleared in active returns to standby, LEDs off.
// - writing 0x55 to soft reset register resets the whole device.
// - supply below threshold register level sets the undervoltage flag.
// - reading interrupt status clears its flags.
// - undervoltage with monitor and protect enabled clears active, halts.
// - undervoltage monitor and protect enables reset to zero.
// - overtemperature at 150C sets flag, releases 20 degrees lower.
// - two bits disable overtemp monitor and protect, enabled by default.
// - overtemp with protection clears chip-active, halts, forces standby.
// - interrupt only when a flag and its enable are both set.
// - level mode holds irq low until status is read.
// - pulse mode gives one low pulse per interrupt, width programmable.
// - eight interrupt sources each with its own enable bit.
// - slave address 0x6A or 0x6B by select pin; lsb is direction.
// - fast mode i2c slave on open-drain clock and data.
// - enable at ground holds the whole device in reset.
// - register pointer follows address byte, advances after each data.
// - reads advance pointer after each master ack.
module slc_sysctl (
  input  wire logic       MCLK,
  input  wire logic       RST,
  input  wire logic       EN,
  input  wire logic       AD,
  input  wire logic       POR_VBAT_LOW,
  input  wire logic       POR_LDO_LOW,
  input  wire logic       UV_TRIP,
  input  wire logic       TEMP_HOT,
  input  wire logic       TEMP_WARM,
  input  wire logic       SCL,
  input  wire logic       SDA_I,
  input  wire logic [5:0] EVT_EXT,
  output logic            SDA_O,
  output logic            SDA_OE,
  output logic            IRQ_OUT_N_O,
  output logic            IRQ_OUT_N_OE,
  output logic            OSC_EN,
  output logic            LDO_FULL,
  output logic            LED_DRV_EN,
  output logic            EFFECT_HALT,
  output logic      [7:0] UV_THRESHOLD
);
  slc_pkg::slc_pm_e pm_q;
  logic       en_s, ad_s, pvb_s, pld_s, uv_s, hot_s, warm_s;
  logic       scl_s, sda_s;
  logic       rst_q, srst_q;
  logic [7:0] gcr_q, icr_q, ier_q, isr_q;
  logic       ot_q, ot_p, uv_p;
  logic [7:0] pcnt_q, pcnt_d;
  logic       wr_stb, rd_stb;
  logic [7:0] reg_addr, wr_data, rd_data;
  logic [7:0] src;
  logic       rd_clr, prot, pend, trig, ev_uv, ev_ot;

  function automatic logic [7:0] pulse_cycles(input logic [7:0] interrupt_control);
    logic [7:0] code;
    code = {5'h00, interrupt_control[slc_pkg::IC_WHI:slc_pkg::IC_WLO]} + 8'h01;
    return 8'(code * slc_pkg::PULSE_UNIT_CYC);
  endfunction

  slc_sync #(.W(9)) u_sync (
    .clk (MCLK),
    .rst (RST),
    .d   ({EN, AD, POR_VBAT_LOW, POR_LDO_LOW, UV_TRIP, TEMP_HOT,
           TEMP_WARM, SCL, SDA_I}),
    .q   ({en_s, ad_s, pvb_s, pld_s, uv_s, hot_s, warm_s, scl_s, sda_s})
  );

  slc_i2c_slave u_i2c (
    .clk      (MCLK),
    .rst      (rst_q),
    .scl      (scl_s),
    .sda      (sda_s),
    .ad       (ad_s),
    .rd_data  (rd_data),
    .sda_oe   (SDA_OE),
    .wr_stb   (wr_stb),
    .rd_stb   (rd_stb),
    .reg_addr (reg_addr),
    .wr_data  (wr_data)
  );

  always_ff @(posedge MCLK) begin
    if (RST) rst_q <= 1'b1;
    else     rst_q <= pvb_s | pld_s | ~en_s | srst_q;
  end

  always_ff @(posedge MCLK) begin
    if (RST) srst_q <= 1'b0;
    else srst_q <= wr_stb && reg_addr == slc_pkg::A_SRST &&
                   wr_data == slc_pkg::SRST_KEY;
  end

  always_ff @(posedge MCLK) begin
    if (rst_q) pm_q <= slc_pkg::PM_SHUT;
    else begin
      unique case (pm_q)
        slc_pkg::PM_SHUT: pm_q <= slc_pkg::PM_STBY;
        slc_pkg::PM_STBY: if (gcr_q[slc_pkg::GC_CHIP])
          pm_q <= slc_pkg::PM_ACT;
        slc_pkg::PM_ACT: if (!gcr_q[slc_pkg::GC_CHIP])
          pm_q <= slc_pkg::PM_STBY;
        // unused fourth code falls back to shutdown
        default: pm_q <= slc_pkg::PM_SHUT;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (rst_q) begin
      OSC_EN      <= 1'b0;
      LDO_FULL    <= 1'b0;
      LED_DRV_EN  <= 1'b0;
      EFFECT_HALT <= 1'b0;
      SDA_O       <= 1'b0;
      IRQ_OUT_N_O <= 1'b0;
    end else begin
      OSC_EN      <= pm_q == slc_pkg::PM_ACT;
      LDO_FULL    <= pm_q == slc_pkg::PM_ACT;
      LED_DRV_EN  <= pm_q == slc_pkg::PM_ACT;
      EFFECT_HALT <= prot & gcr_q[slc_pkg::GC_CHIP];
      SDA_O       <= 1'b0;
      IRQ_OUT_N_O <= 1'b0;
    end
  end

  assign prot = (uv_s & gcr_q[slc_pkg::GC_UNDERVOLTAGE_MONITOR_ENABLE] & gcr_q[slc_pkg::GC_UVPE])
              | (ot_q & ~gcr_q[slc_pkg::GC_OVERTEMP_PROTECT_DISABLE]);

  always_ff @(posedge MCLK) begin
    if (rst_q) begin
      gcr_q        <= slc_pkg::GCR_RST;
      icr_q        <= slc_pkg::ICR_RST;
      ier_q        <= slc_pkg::IER_RST;
      UV_THRESHOLD <= slc_pkg::UVT_RST;
    end else begin
      if (wr_stb) begin
        unique case (reg_addr)
          slc_pkg::A_GCR: gcr_q        <= wr_data;
          slc_pkg::A_ICR: icr_q        <= wr_data;
          slc_pkg::A_IER: ier_q        <= wr_data;
          slc_pkg::A_UVT: UV_THRESHOLD <= wr_data;
          default: ;
        endcase
      end
      if (prot) gcr_q[slc_pkg::GC_CHIP] <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (rst_q) begin
      ot_q <= 1'b0;
      ot_p <= 1'b0;
      uv_p <= 1'b0;
    end else begin
      if (hot_s)       ot_q <= 1'b1;
      else if (!warm_s) ot_q <= 1'b0;
      ot_p <= ot_q;
      uv_p <= uv_s;
    end
  end

  assign ev_uv = uv_s & ~uv_p & gcr_q[slc_pkg::GC_UNDERVOLTAGE_MONITOR_ENABLE];
  assign ev_ot = ot_q & ~ot_p & ~gcr_q[slc_pkg::GC_OVERTEMP_MONITOR_DISABLE];
  assign src   = {EVT_EXT, ev_ot, ev_uv};
  assign rd_clr = rd_stb && reg_addr == slc_pkg::A_ISR;

  for (genvar g = 0; g < slc_pkg::NSRC; g++) begin : g_isr
    always_ff @(posedge MCLK) begin
      if (rst_q) isr_q[g] <= slc_pkg::ISR_RST[g];
      else       isr_q[g] <= src[g] | (isr_q[g] & ~rd_clr);
    end
  end

  always_comb begin
    unique case (reg_addr)
      slc_pkg::A_GCR: rd_data = gcr_q;
      slc_pkg::A_ICR: rd_data = icr_q;
      slc_pkg::A_IER: rd_data = ier_q;
      slc_pkg::A_ISR: rd_data = isr_q;
      slc_pkg::A_UVT: rd_data = UV_THRESHOLD;
      default:        rd_data = 8'h00;
    endcase
  end

  assign pend = |(isr_q & ier_q);
  assign trig = |(src & ier_q);

  always_comb begin
    if (icr_q[slc_pkg::IC_MODE] && trig && pcnt_q == 8'h00)
      pcnt_d = pulse_cycles(icr_q);
    else if (pcnt_q != 8'h00)
      pcnt_d = pcnt_q - 8'h01;
    else
      pcnt_d = 8'h00;
  end

  always_ff @(posedge MCLK) begin
    if (rst_q) begin
      pcnt_q       <= 8'h00;
      IRQ_OUT_N_OE <= 1'b0;
    end else begin
      pcnt_q       <= pcnt_d;
      IRQ_OUT_N_OE <= icr_q[slc_pkg::IC_MODE] ? pcnt_d != 8'h00 : pend;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  property p_srst;
    wr_stb && reg_addr == slc_pkg::A_SRST && wr_data == slc_pkg::SRST_KEY
      |-> ##3 (gcr_q == slc_pkg::GCR_RST &&
               UV_THRESHOLD == slc_pkg::UVT_RST);
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset missed");

  property p_shut;
    !en_s |-> ##2 (pm_q == slc_pkg::PM_SHUT && !SDA_OE);
  endproperty
  a_shut: assert property (p_shut) else $error("not shut");

  property p_act;
    pm_q == slc_pkg::PM_STBY && gcr_q[slc_pkg::GC_CHIP] && !rst_q
      |=> pm_q == slc_pkg::PM_ACT ##1 (OSC_EN && LDO_FULL);
  endproperty
  a_act: assert property (p_act) else $error("no activate");

  property p_deact;
    pm_q == slc_pkg::PM_ACT && !gcr_q[slc_pkg::GC_CHIP] && !rst_q
      |=> pm_q != slc_pkg::PM_ACT ##1 !LED_DRV_EN;
  endproperty
  a_deact: assert property (p_deact) else $error("no standby");

  property p_uvflag;
    !rst_q && ev_uv |=> isr_q[slc_pkg::IS_UV];
  endproperty
  a_uvflag: assert property (p_uvflag) else $error("uv flag");

  property p_rdclr;
    !rst_q && rd_clr && src == 8'h00 |=> isr_q == 8'h00;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("no clear");

  property p_uvprot;
    !rst_q && uv_s && gcr_q[slc_pkg::GC_UNDERVOLTAGE_MONITOR_ENABLE] && gcr_q[slc_pkg::GC_UVPE]
      |=> !gcr_q[slc_pkg::GC_CHIP];
  endproperty
  a_uvprot: assert property (p_uvprot) else $error("uv prot");

  property p_otflag;
    !rst_q && $rose(ot_q) && !gcr_q[slc_pkg::GC_OVERTEMP_MONITOR_DISABLE]
      |=> isr_q[slc_pkg::IS_OT];
  endproperty
  a_otflag: assert property (p_otflag) else $error("ot flag");

  property p_otprot;
    !rst_q && ot_q && !gcr_q[slc_pkg::GC_OVERTEMP_PROTECT_DISABLE]
      |=> !gcr_q[slc_pkg::GC_CHIP];
  endproperty
  a_otprot: assert property (p_otprot) else $error("ot prot");

  property p_level;
    !rst_q && !icr_q[slc_pkg::IC_MODE] && $stable(icr_q[slc_pkg::IC_MODE])
      |=> IRQ_OUT_N_OE == $past(pend);
  endproperty
  a_level: assert property (p_level) else $error("level irq");

  property p_pulse;
    !rst_q && icr_q[slc_pkg::IC_MODE] && trig && pcnt_q == 8'h00
      |=> IRQ_OUT_N_OE[*2] ##0 pcnt_q == pulse_cycles($past(icr_q)) - 8'h01;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse irq");

  c_act:   cover property (pm_q == slc_pkg::PM_ACT);
  c_read:  cover property (rd_clr && isr_q != 8'h00);
  c_pulse: cover property ($fell(IRQ_OUT_N_OE) && icr_q[0]);
endmodule // slc_sysctl

// ### slc_pkg.sv
// system-control constants, register map and state types
// assumes a single 20 MHz system clock domain
package slc_pkg;
  localparam logic [7:0] A_SRST = 8'h01;
  localparam logic [7:0] A_GCR  = 8'h02;
  localparam logic [7:0] A_ICR  = 8'h08;
  localparam logic [7:0] A_IER  = 8'h09;
  localparam logic [7:0] A_ISR  = 8'h0A;
  localparam logic [7:0] A_UVT  = 8'h10;
  localparam logic [7:0] SRST_KEY = 8'h55;
  localparam logic [7:0] GCR_RST  = 8'h00;
  localparam logic [7:0] ICR_RST  = 8'h00;
  localparam logic [7:0] IER_RST  = 8'h00;
  localparam logic [7:0] ISR_RST  = 8'h00;
  localparam logic [7:0] UVT_RST  = 8'h03;
  // global control fields
  localparam int GC_CHIP = 0;
  localparam int GC_UNDERVOLTAGE_MONITOR_ENABLE = 1;
  localparam int GC_UVPE = 2;
  localparam int GC_OVERTEMP_MONITOR_DISABLE = 3;
  localparam int GC_OVERTEMP_PROTECT_DISABLE = 4;
  // interrupt control fields
  localparam int IC_MODE = 0;
  localparam int IC_WLO  = 1;
  localparam int IC_WHI  = 3;
  // status bit positions
  localparam int IS_UV = 0;
  localparam int IS_OT = 1;
  localparam int NSRC  = 8;
  // slave addresses, address-select low and high
  localparam logic [6:0] DEV_ADDR_LO = 7'h6A;
  localparam logic [6:0] DEV_ADDR_HI = 7'h6B;
  // irq pulse width unit
  localparam int CLK_NS       = 50;
  localparam int PULSE_UNIT_NS = 1000;
  localparam logic [7:0] PULSE_UNIT_CYC =
    8'((PULSE_UNIT_NS + CLK_NS - 1) / CLK_NS);
  typedef enum logic [1:0] {PM_SHUT, PM_STBY, PM_ACT} slc_pm_e;
  typedef enum logic [3:0] {
    I_IDLE, I_DEV, I_DACK, I_REG, I_RACK, I_WR, I_WACK, I_TX, I_MACK
  } slc_i2c_e;
endpackage

// ### slc_sync.sv
// two-flop synchroniser for a group of unrelated levels
// assumes each bit is an independent asynchronous level
module slc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // slc_sync

// ### slc_i2c_slave.sv
// i2c slave byte engine with auto-incrementing register pointer
// assumes scl and sda already synchronised to clk
module slc_i2c_slave (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ad,
  input  wire logic [7:0] rd_data,
  output logic            sda_oe,
  output logic            wr_stb,
  output logic            rd_stb,
  output logic      [7:0] reg_addr,
  output logic      [7:0] wr_data
);
  slc_pkg::slc_i2c_e st_q;
  logic       scl_p;
  logic       sda_p;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  logic [7:0] tx_q;
  logic       rw_q;
  logic       mack_q;
  logic       scl_r;
  logic       scl_f;
  logic       start;
  logic       stop;
  logic [6:0] my_addr;

  assign scl_r = scl & ~scl_p;
  assign scl_f = ~scl & scl_p;
  assign start = scl & scl_p & sda_p & ~sda;
  assign stop  = scl & scl_p & ~sda_p & sda;
  assign my_addr = ad ? slc_pkg::DEV_ADDR_HI : slc_pkg::DEV_ADDR_LO;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl;
      sda_p <= sda;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q     <= slc_pkg::I_IDLE;
      cnt_q    <= 4'h0;
      sr_q     <= 8'h00;
      tx_q     <= 8'h00;
      rw_q     <= 1'b0;
      mack_q   <= 1'b0;
      sda_oe   <= 1'b0;
      wr_stb   <= 1'b0;
      rd_stb   <= 1'b0;
      reg_addr <= 8'h00;
      wr_data  <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (rd_stb) begin
        tx_q   <= rd_data;
        sda_oe <= ~rd_data[7];
      end
      if (stop) begin
        st_q   <= slc_pkg::I_IDLE;
        sda_oe <= 1'b0;
      end else if (start) begin
        st_q   <= slc_pkg::I_DEV;
        cnt_q  <= 4'h0;
        sda_oe <= 1'b0;
      end else if (scl_r) begin
        if (st_q == slc_pkg::I_DEV || st_q == slc_pkg::I_REG ||
            st_q == slc_pkg::I_WR) begin
          sr_q  <= {sr_q[6:0], sda};
          cnt_q <= cnt_q + 4'h1;
        end
        if (st_q == slc_pkg::I_MACK) mack_q <= ~sda;
      end else if (scl_f) begin
        unique case (st_q)
          slc_pkg::I_IDLE: ;
          slc_pkg::I_DEV: if (cnt_q == 4'h8) begin
            if (sr_q[7:1] == my_addr) begin
              st_q   <= slc_pkg::I_DACK;
              sda_oe <= 1'b1;
              rw_q   <= sr_q[0];
            end else begin
              st_q <= slc_pkg::I_IDLE;
            end
          end
          slc_pkg::I_DACK: begin
            sda_oe <= 1'b0;
            cnt_q  <= 4'h0;
            if (rw_q) begin
              st_q   <= slc_pkg::I_TX;
              rd_stb <= 1'b1;
            end else begin
              st_q <= slc_pkg::I_REG;
            end
          end
          slc_pkg::I_REG: if (cnt_q == 4'h8) begin
            reg_addr <= sr_q;
            st_q     <= slc_pkg::I_RACK;
            sda_oe   <= 1'b1;
          end
          slc_pkg::I_RACK: begin
            sda_oe <= 1'b0;
            cnt_q  <= 4'h0;
            st_q   <= slc_pkg::I_WR;
          end
          slc_pkg::I_WR: if (cnt_q == 4'h8) begin
            wr_stb  <= 1'b1;
            wr_data <= sr_q;
            st_q    <= slc_pkg::I_WACK;
            sda_oe  <= 1'b1;
          end
          slc_pkg::I_WACK: begin
            reg_addr <= reg_addr + 8'h01;
            sda_oe   <= 1'b0;
            cnt_q    <= 4'h0;
            st_q     <= slc_pkg::I_WR;
          end
          slc_pkg::I_TX: if (cnt_q == 4'h7) begin
            st_q   <= slc_pkg::I_MACK;
            sda_oe <= 1'b0;
          end else begin
            cnt_q  <= cnt_q + 4'h1;
            tx_q   <= {tx_q[6:0], 1'b0};
            sda_oe <= ~tx_q[6];
          end
          slc_pkg::I_MACK: if (mack_q) begin
            reg_addr <= reg_addr + 8'h01;
            st_q     <= slc_pkg::I_TX;
            cnt_q    <= 4'h0;
          end else begin
            st_q <= slc_pkg::I_IDLE;
          end
          default: st_q <= slc_pkg::I_IDLE;
        endcase
      end
      if (scl_f && st_q == slc_pkg::I_MACK && mack_q) rd_stb <= 1'b1;
    end
  end
endmodule // slc_i2c_slave

// ### slc_host.sv
// i2c controller model: drives scl and the open-drain data line
// assumes a pull-up on sda; sda_rel high releases the line
module slc_host (
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic start();
    #13 sda_rel = 1'b1;
    #200 scl = 1'b1;
    #200 sda_rel = 1'b0;
    #200 scl = 1'b0;
  endtask
  task automatic stop();
    #100 sda_rel = 1'b0;
    #100 scl = 1'b1;
    #200 sda_rel = 1'b1;
    #400;
  endtask
  // data moves only while scl low
  task automatic bitx(input logic b, output logic r);
    #100 sda_rel = b;
    #100 scl = 1'b1;
    #200 r = sda;
    scl = 1'b0;
  endtask
  // msb first, ninth bit from m9
  task automatic xbyte(input logic [7:0] d, input logic m9,
                       output logic [7:0] q, output logic a9);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(m9, a9);
  endtask
  // address, pointer, then n data bytes
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                    input logic [15:0] d, input int n, output logic ok);
    logic [7:0] q;
    logic       a;
    start();
    xbyte({dev, 1'b0}, 1'b1, q, a);
    ok = !a;
    xbyte(ptr, 1'b1, q, a);
    for (int i = 0; i < n; i++) begin
      xbyte(d[15-8*i -: 8], 1'b1, q, a);
    end
    stop();
  endtask
  // pointer, repeated start, ack all but the last byte
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
                    input int n, output logic [15:0] d, output logic ok);
    logic [7:0] q;
    logic       a;
    start();
    xbyte({dev, 1'b0}, 1'b1, q, a);
    ok = !a;
    xbyte(ptr, 1'b1, q, a);
    start();
    xbyte({dev, 1'b1}, 1'b1, q, a);
    for (int i = 0; i < n; i++) begin
      xbyte(8'hFF, (i == n - 1), q, a);
      d[15-8*i -: 8] = q;
    end
    stop();
  endtask
endmodule // slc_host

// ### test_slc_sysctl.sv
// self-checking bench for the system-control block
// assumes slc_host as i2c controller and a pull-up on sda
module test_slc_sysctl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 40000;
  logic        MCLK, RST, EN, AD, POR_VBAT_LOW, POR_LDO_LOW;
  logic        UV_TRIP, TEMP_HOT, TEMP_WARM, SDA_O, SDA_OE;
  logic        IRQ_OUT_N_O, IRQ_OUT_N_OE, OSC_EN, LDO_FULL;
  logic        LED_DRV_EN, EFFECT_HALT, scl, sda_rel, ok, ack_exp;
  logic        halt_seen;
  logic [5:0]  EVT_EXT;
  logic [7:0]  UV_THRESHOLD;
  logic [6:0]  dev;
  logic [15:0] q16, b16;
  logic [2:0]  wv;
  logic [7:0]  u;
  int          err_count, checked, cyc, n, seed;
  wire         sda_line = sda_rel & !(SDA_OE && !SDA_O);
  wire         irq_line = !(IRQ_OUT_N_OE && !IRQ_OUT_N_O);
  wire  [7:0]  pm = {5'h00, OSC_EN, LDO_FULL, LED_DRV_EN};
  slc_sysctl u_slc_sysctl (.MCLK(MCLK), .RST(RST), .EN(EN), .AD(AD),
    .POR_VBAT_LOW(POR_VBAT_LOW), .POR_LDO_LOW(POR_LDO_LOW),
    .UV_TRIP(UV_TRIP), .TEMP_HOT(TEMP_HOT), .TEMP_WARM(TEMP_WARM),
    .SCL(scl), .SDA_I(sda_line), .EVT_EXT(EVT_EXT), .SDA_O(SDA_O),
    .SDA_OE(SDA_OE), .IRQ_OUT_N_O(IRQ_OUT_N_O),
    .IRQ_OUT_N_OE(IRQ_OUT_N_OE), .OSC_EN(OSC_EN), .LDO_FULL(LDO_FULL),
    .LED_DRV_EN(LED_DRV_EN), .EFFECT_HALT(EFFECT_HALT),
    .UV_THRESHOLD(UV_THRESHOLD));
  slc_host u_slc_host (.scl(scl), .sda_rel(sda_rel), .sda(sda_line));
  always #25 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    if (EFFECT_HALT === 1'b1) halt_seen = 1'b1;
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      results();
    end
  end
  function automatic logic [7:0] pulse_cyc(input logic [2:0] w);
    return 8'((w + 1) * slc_pkg::PULSE_UNIT_CYC);
  endfunction
  task automatic results();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge MCLK);
  endtask
  task automatic w(input logic [7:0] p, input logic [7:0] d);
    u_slc_host.wr(dev, p, {d, 8'h00}, 1, ok);
    chk1(ok, ack_exp);
    tick(1);
  endtask
  task automatic r(input logic [7:0] p, input logic [7:0] e);
    u_slc_host.rd(dev, p, 1, q16, ok);
    chk1(ok, ack_exp);
    chk8(q16[15:8], e);
    tick(1);
  endtask
  task automatic evt(input int k);
    EVT_EXT = 6'(1 << k);
    tick(1);
    EVT_EXT = 6'h00;
  endtask
  task automatic hot(input logic v);
    TEMP_WARM = v;
    TEMP_HOT = v;
    tick(8);
  endtask
  initial begin
    {MCLK, RST, EN, AD, POR_VBAT_LOW, POR_LDO_LOW} = 6'h38;
    {UV_TRIP, TEMP_HOT, TEMP_WARM, halt_seen} = 4'h0;
    EVT_EXT = 6'h00;
    dev = slc_pkg::DEV_ADDR_LO;
    ack_exp = 1'b1;
    seed = $urandom(6762);
    tick(20);
    RST = 1'b0;
    tick(10);
    r(slc_pkg::A_GCR, 8'h00);
    r(slc_pkg::A_ICR, 8'h00);
    r(slc_pkg::A_IER, 8'h00);
    r(slc_pkg::A_UVT, 8'h03);
    chk8(pm, 8'h00);
    w(slc_pkg::A_GCR, 8'h01);
    tick(3);
    chk8(pm, 8'h07);
    UV_TRIP = 1'b1;
    tick(6);
    chk8(pm, 8'h07);
    r(slc_pkg::A_ISR, 8'h00);
    UV_TRIP = 1'b0;
    w(slc_pkg::A_GCR, 8'h07);
    halt_seen = 1'b0;
    UV_TRIP = 1'b1;
    tick(6);
    chk8(pm, 8'h00);
    chk1(halt_seen, 1'b1);
    r(slc_pkg::A_GCR, 8'h06);
    r(slc_pkg::A_ISR, 8'h01);
    r(slc_pkg::A_ISR, 8'h00);
    UV_TRIP = 1'b0;
    w(slc_pkg::A_GCR, 8'h01);
    w(slc_pkg::A_GCR, 8'h00);
    tick(3);
    chk8(pm, 8'h00);
    w(slc_pkg::A_GCR, 8'h01);
    hot(1'b1);
    chk8(pm, 8'h00);
    r(slc_pkg::A_GCR, 8'h00);
    r(slc_pkg::A_ISR, 8'h02);
    TEMP_HOT = 1'b0;
    tick(8);
    TEMP_HOT = 1'b1;
    tick(8);
    r(slc_pkg::A_ISR, 8'h00);
    hot(1'b0);
    w(slc_pkg::A_GCR, 8'h11);
    hot(1'b1);
    chk8(pm, 8'h07);
    r(slc_pkg::A_ISR, 8'h02);
    hot(1'b0);
    w(slc_pkg::A_GCR, 8'h19);
    hot(1'b1);
    r(slc_pkg::A_ISR, 8'h00);
    hot(1'b0);
    w(slc_pkg::A_GCR, 8'h00);
    b16 = 16'($urandom);
    u_slc_host.wr(dev, slc_pkg::A_ICR, b16, 2, ok);
    u_slc_host.rd(dev, slc_pkg::A_ICR, 2, q16, ok);
    chk8(q16[15:8], b16[15:8]);
    chk8(q16[7:0], b16[7:0]);
    r(8'h20, 8'h00);
    w(slc_pkg::A_ICR, 8'h00);
    w(slc_pkg::A_IER, 8'h00);
    r(slc_pkg::A_ISR, 8'h00);
    evt(1);
    tick(3);
    chk1(IRQ_OUT_N_OE, 1'b0);
    r(slc_pkg::A_ISR, 8'h08);
    w(slc_pkg::A_IER, 8'h04);
    evt(0);
    tick(3);
    chk1(irq_line, 1'b0);
    tick(40);
    chk1(IRQ_OUT_N_OE, 1'b1);
    r(slc_pkg::A_ISR, 8'h04);
    tick(3);
    chk1(IRQ_OUT_N_OE, 1'b0);
    w(slc_pkg::A_IER, 8'hFC);
    for (int k = 0; k < 6; k++) begin
      wv = 3'($urandom_range(7, 0));
      w(slc_pkg::A_ICR, {4'h0, wv, 1'b1});
      evt(k);
      for (int j = 0; j < 10 && IRQ_OUT_N_OE !== 1'b1; j++) tick(1);
      n = 0;
      while (IRQ_OUT_N_OE === 1'b1 && n < 400) begin
        n++;
        tick(1);
      end
      chk8(8'(n), pulse_cyc(wv));
      tick(30);
      chk1(IRQ_OUT_N_OE, 1'b0);
      r(slc_pkg::A_ISR, 8'(1 << (k + 2)));
    end
    u = 8'($urandom_range(255, 0));
    w(slc_pkg::A_UVT, u);
    w(slc_pkg::A_IER, 8'h5A);
    chk8(UV_THRESHOLD, u);
    w(slc_pkg::A_SRST, 8'h12);
    r(slc_pkg::A_IER, 8'h5A);
    w(slc_pkg::A_SRST, 8'h55);
    tick(5);
    r(slc_pkg::A_IER, 8'h00);
    chk8(UV_THRESHOLD, 8'h03);
    for (int p = 0; p < 2; p++) begin
      w(slc_pkg::A_IER, 8'h33);
      {POR_LDO_LOW, POR_VBAT_LOW} = 2'(1 << p);
      tick(3);
      {POR_LDO_LOW, POR_VBAT_LOW} = 2'h0;
      tick(10);
      r(slc_pkg::A_IER, 8'h00);
    end
    AD = 1'b1;
    tick(5);
    ack_exp = 1'b0;
    w(slc_pkg::A_IER, 8'h11);
    dev = slc_pkg::DEV_ADDR_HI;
    ack_exp = 1'b1;
    r(slc_pkg::A_IER, 8'h00);
    AD = 1'b0;
    dev = slc_pkg::DEV_ADDR_LO;
    tick(5);
    w(slc_pkg::A_GCR, 8'h01);
    EN = 1'b0;
    tick(10);
    chk8(pm, 8'h00);
    ack_exp = 1'b0;
    w(slc_pkg::A_IER, 8'h22);
    EN = 1'b1;
    tick(10);
    ack_exp = 1'b1;
    chk8(pm, 8'h00);
    r(slc_pkg::A_GCR, 8'h00);
    r(slc_pkg::A_IER, 8'h00);
    results();
  end
endmodule // test_slc_sysctl
